// ===== hw/ilvl_defs.vh
// Constants for the interrupt level assignment block.
// Assumes inclusion by bare name from hw/ files only.
//
// What this block does
// - Group one bits 26:24 hold timer channel 2 level, request line 19.
// - Group one bits 18:16 hold timer channel 1 level, request line 18.
// - Group one bits 10:8 hold external pin 1 level, request line 3.
// - Group one bits 2:0 hold external pin 0 level, request line 2.
// - Group two bits 26:24 hold NAND controller level, request line 21.
// - Group two bits 10:8 hold shared pin 3 / Ethernet level, line 5.
// - Group two bits 2:0 hold external pin 2 level, request line 4.
// - Level 000 disables a source; its request never goes forward.
// - Codes 001 to 111 select active levels 1 to 7 in binary.
// - After reset every level field is 000, all sources disabled.
`ifndef ILVL_DEFS_VH
`define ILVL_DEFS_VH

`define ILVL_ADDR_W        16
`define ILVL_OFF_GRP1      16'hf614
`define ILVL_OFF_GRP2      16'hf618
`define ILVL_OFF_STAT      16'hf640
`define ILVL_OFF_MASK      16'hf644
`define ILVL_NSRC          7
`define ILVL_LVL_W         3
`define ILVL_LVL_OFF       3'h0
`define ILVL_F_HI_LSB      24
`define ILVL_F_MID_LSB     16
`define ILVL_F_LOW1_LSB    8
`define ILVL_F_LOW0_LSB    0
`define ILVL_GRP1_MASK     32'h07070707
`define ILVL_GRP2_MASK     32'h07000707
`define ILVL_SRC_MASK      7'h7f
`define ILVL_ZERO32        32'h00000000
`define ILVL_ZERO7         7'h00
`define ILVL_ZERO21        21'h0
`define ILVL_ZERO25        25'h0
`define ILVL_RESP_OKAY     2'h0
`define ILVL_RESP_SLVERR   2'h2
// Source index order on the source and level ports
`define ILVL_S_EXT0        0
`define ILVL_S_EXT1        1
`define ILVL_S_EXT2        2
`define ILVL_S_EXT3        3
`define ILVL_S_TMR1        4
`define ILVL_S_TMR2        5
`define ILVL_S_NAND        6

`endif

// ===== hw/ilvl_gate.v
// Gating of one source by its level field.
// Assumes the request is synchronous to the system clock.
`include "ilvl_defs.vh"
`default_nettype none

module ilvl_gate (
    input  wire       i_req,
    input  wire [2:0] i_level,
    output wire       o_fwd,
    output wire [2:0] o_level
);
    // Level zero blocks the source
    assign o_fwd   = i_req & (i_level != `ILVL_LVL_OFF);
    assign o_level = o_fwd ? i_level : `ILVL_LVL_OFF;
endmodule

`default_nettype wire

// ===== hw/ilvl_top.v
// Interrupt level assignment: two level registers, event status and mask.
// Assumes an Avalon-MM master on the system clock; sources are synchronous.
//
// Register access over Avalon-MM was decided locally.
`include "ilvl_defs.vh"
`default_nettype none

module ilvl_top (
    input  wire        i_mclk,
    input  wire        i_rst_n,
    input  wire [15:0] i_address,
    input  wire        i_read,
    input  wire        i_write,
    input  wire [31:0] i_writedata,
    input  wire [3:0]  i_byteenable,
    output reg  [31:0] o_readdata,
    output reg         o_waitrequest,
    output reg  [1:0]  o_response,
    input  wire [6:0]  i_src_req,
    output reg  [6:0]  o_src_fwd,
    output reg  [20:0] o_src_level,
    output reg         o_irq
);
    reg  [31:0] grp1_reg;
    reg  [31:0] grp2_reg;
    reg  [6:0]  stat_reg;
    reg  [6:0]  mask_reg;
    reg         done_reg;
    reg  [6:0]  req_dly_reg;
    wire [20:0] lvl_all;
    wire [6:0]  fwd_all;
    wire [20:0] lvl_gated;
    wire        acc;
    wire        hit;
    wire [31:0] bemask;
    wire [6:0]  rise;
    wire [6:0]  stat_next;

    function [31:0] be_expand;
        input [3:0] be;
        begin
            be_expand = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    function [2:0] fld;
        input [31:0] r;
        input integer lsb;
        begin
            fld = r[lsb +: 3];
        end
    endfunction

    function valid_addr;
        input [15:0] a;
        begin
            valid_addr = (a == `ILVL_OFF_GRP1) || (a == `ILVL_OFF_GRP2) ||
                         (a == `ILVL_OFF_STAT) || (a == `ILVL_OFF_MASK);
        end
    endfunction

    // Levels per source index
    assign lvl_all[3*`ILVL_S_EXT0 +: 3] = fld(grp1_reg, `ILVL_F_LOW0_LSB);
    assign lvl_all[3*`ILVL_S_EXT1 +: 3] = fld(grp1_reg, `ILVL_F_LOW1_LSB);
    assign lvl_all[3*`ILVL_S_TMR1 +: 3] = fld(grp1_reg, `ILVL_F_MID_LSB);
    assign lvl_all[3*`ILVL_S_TMR2 +: 3] = fld(grp1_reg, `ILVL_F_HI_LSB);
    assign lvl_all[3*`ILVL_S_EXT2 +: 3] = fld(grp2_reg, `ILVL_F_LOW0_LSB);
    assign lvl_all[3*`ILVL_S_EXT3 +: 3] = fld(grp2_reg, `ILVL_F_LOW1_LSB);
    assign lvl_all[3*`ILVL_S_NAND +: 3] = fld(grp2_reg, `ILVL_F_HI_LSB);

    genvar g;
    generate
        for (g = 0; g < `ILVL_NSRC; g = g + 1) begin : gen_gate
            ilvl_gate u_gate (
                .i_req   (i_src_req[g]),
                .i_level (lvl_all[3*g +: 3]),
                .o_fwd   (fwd_all[g]),
                .o_level (lvl_gated[3*g +: 3])
            );
        end
    endgenerate

    assign acc    = (i_read | i_write) & ~done_reg;
    assign hit    = valid_addr(i_address);
    assign bemask = be_expand(i_byteenable);
    // Newly forwarded request is an event
    assign rise   = fwd_all & ~req_dly_reg;
    // Set wins over write-one-to-clear
    assign stat_next = (stat_reg & ~((acc & i_write & hit &
                        (i_address == `ILVL_OFF_STAT)) ? i_writedata[6:0] & bemask[6:0]
                        : `ILVL_ZERO7)) | rise;

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            grp1_reg      <= `ILVL_ZERO32;
            grp2_reg      <= `ILVL_ZERO32;
            stat_reg      <= `ILVL_ZERO7;
            mask_reg      <= `ILVL_ZERO7;
            done_reg      <= 1'b0;
            req_dly_reg   <= `ILVL_ZERO7;
            o_readdata    <= `ILVL_ZERO32;
            o_waitrequest <= 1'b1;
            o_response    <= `ILVL_RESP_OKAY;
            o_src_fwd     <= `ILVL_ZERO7;
            o_src_level   <= `ILVL_ZERO21;
            o_irq         <= 1'b0;
        end else begin
            req_dly_reg <= fwd_all;
            stat_reg    <= stat_next;
            o_src_fwd   <= fwd_all;
            o_src_level <= lvl_gated;
            o_irq       <= |(stat_next & mask_reg);
            // Answer one cycle after request; release next cycle
            done_reg      <= acc;
            o_waitrequest <= ~acc;
            o_response    <= (acc && !hit) ? `ILVL_RESP_SLVERR : `ILVL_RESP_OKAY;
            if (acc && i_write && hit) begin
                case (i_address)
                    `ILVL_OFF_GRP1: begin
                        grp1_reg <= ((grp1_reg & ~bemask) | (i_writedata & bemask))
                                    & `ILVL_GRP1_MASK;
                    end
                    `ILVL_OFF_GRP2: begin
                        grp2_reg <= ((grp2_reg & ~bemask) | (i_writedata & bemask))
                                    & `ILVL_GRP2_MASK;
                    end
                    `ILVL_OFF_MASK: begin
                        mask_reg <= ((mask_reg & ~bemask[6:0]) |
                                     (i_writedata[6:0] & bemask[6:0])) & `ILVL_SRC_MASK;
                    end
                    default: begin
                        mask_reg <= mask_reg;
                    end
                endcase
            end
            if (acc && i_read) begin
                case (i_address)
                    `ILVL_OFF_GRP1: o_readdata <= grp1_reg & `ILVL_GRP1_MASK;
                    `ILVL_OFF_GRP2: o_readdata <= grp2_reg & `ILVL_GRP2_MASK;
                    `ILVL_OFF_STAT: o_readdata <= {`ILVL_ZERO25, stat_reg};
                    `ILVL_OFF_MASK: o_readdata <= {`ILVL_ZERO25, mask_reg};
                    default:        o_readdata <= `ILVL_ZERO32;
                endcase
            end
        end
    end
endmodule

`default_nettype wire

// ===== tb/ilvl_core_model.sv
// Core side: picks the highest level among forwarded requests.
// Assumes registered forward and level vectors from the block.
`default_nettype none
module ilvl_core_model (
    input  wire logic [6:0]  i_fwd,
    input  wire logic [20:0] i_level,
    output var  logic [2:0]  o_top
);
    timeunit 1ns;
    timeprecision 1ns;
    always_comb begin
        o_top = 3'h0;
        for (int k = 0; k < 7; k++) begin
            if (i_fwd[k] && i_level[k*3+:3] > o_top) begin
                o_top = i_level[k*3+:3];
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/ilvl_properties.sv
// Checker for the level block top, bound to every ilvl_top.
// Assumes the top's port names and widths.
`default_nettype none
module ilvl_properties (
    input wire logic        i_mclk,
    input wire logic        i_rst_n,
    input wire logic        i_read,
    input wire logic        i_write,
    input wire logic        o_waitrequest,
    input wire logic        o_irq,
    input wire logic [15:0] i_address,
    input wire logic [31:0] o_readdata,
    input wire logic [1:0]  o_response,
    input wire logic [6:0]  i_src_req,
    input wire logic [6:0]  o_src_fwd,
    input wire logic [20:0] o_src_level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] nz;
    wire        rd_done = i_read && !o_waitrequest;
    wire        unm = !(i_address inside {16'hf614, 16'hf618, 16'hf640, 16'hf644});
    always_comb for (int k = 0; k < 7; k++) nz[k] = |o_src_level[k*3+:3];
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    property p_lvl; o_src_fwd == nz; endproperty
    a_lvl: assert property (p_lvl) else $error("forward and level disagree");
    property p_req; (o_src_fwd & ~$past(i_src_req)) == 7'h0; endproperty
    a_req: assert property (p_req) else $error("forward without request");
    property p_ans; $rose(i_read || i_write) |=> !o_waitrequest; endproperty
    a_ans: assert property (p_ans) else $error("no answer after one wait");
    property p_one; !o_waitrequest |=> o_waitrequest; endproperty
    a_one: assert property (p_one) else $error("answer held too long");
    property p_idle; !(i_read || i_write) |-> o_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_g1; rd_done && i_address == 16'hf614 |-> !(o_readdata & 32'hf8f8f8f8);
    endproperty
    a_g1: assert property (p_g1) else $error("group one spare bits set");
    property p_g2; rd_done && i_address == 16'hf618 |-> !(o_readdata & 32'hf8fff8f8);
    endproperty
    a_g2: assert property (p_g2) else $error("group two spare bits set");
    property p_unm; rd_done && unm |-> o_readdata == 32'h0 && o_response == 2'h2; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not refused");
    c_wr: cover property (i_write && !o_waitrequest);
    c_unm: cover property (rd_done && unm);
    c_irq: cover property ($rose(o_irq));
endmodule
bind ilvl_top ilvl_properties ilvl_properties_inst (.i_mclk, .i_rst_n, .i_read, .i_write,
    .o_waitrequest, .o_irq, .i_address, .o_readdata, .o_response, .i_src_req, .o_src_fwd,
    .o_src_level);
`default_nettype wire

// ===== tb/testbench.sv
// Bench: registers, source forwarding and interrupt through bus calls.
// Assumes ilvl_top, the core model and the bound checker.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_mclk = 0, i_rst_n = 0, i_read = 0, i_write = 0, o_waitrequest, o_irq;
    logic [15:0] i_address = 16'h0;
    logic [31:0] i_writedata = 32'h0, o_readdata, q;
    logic [6:0]  i_src_req = 7'h0, o_src_fwd;
    logic [1:0]  o_response, rsp;
    logic [3:0]  be = 4'hf;
    logic [20:0] o_src_level;
    logic [2:0]  top;
    int          mismatches = 0, tests_run = 0, cyc = 0;
    ilvl_top ilvl_top_inst (.i_mclk, .i_rst_n, .i_address, .i_read, .i_write, .i_writedata,
        .i_byteenable(be), .o_readdata, .o_waitrequest, .o_response, .i_src_req,
        .o_src_fwd, .o_src_level, .o_irq);
    ilvl_core_model ilvl_core_model_inst (.i_fwd(o_src_fwd), .i_level(o_src_level), .o_top(top));
    always #20 i_mclk = ~i_mclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_address <= a;
        i_write <= w;
        i_read <= !w;
        i_writedata <= d;
        do @(posedge i_mclk); while (o_waitrequest !== 1'b0);
        q = o_readdata;
        rsp = o_response;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask
    task automatic give_verdict;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            give_verdict;
        end
    end
    initial begin
        repeat (12) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        acc(0, 16'hf614, 0);
        chk(q, 0);
        acc(0, 16'hf618, 0);
        chk(q, 0);
        acc(1, 16'hf614, 32'hffffffff);
        acc(0, 16'hf614, 0);
        chk(q, 32'h07070707);
        acc(1, 16'hf618, 32'hffffffff);
        acc(0, 16'hf618, 0);
        chk(q, 32'h07000707);
        acc(0, 16'hf600, 0);
        chk(q, 32'h0);
        chk(rsp, 32'h2);
        acc(1, 16'hf614, 32'h05030601);
        acc(1, 16'hf618, 32'h07000400);
        acc(0, 16'hf614, 0);
        chk(q, 32'h05030601);
        chk(rsp, 32'h0);
        i_src_req <= 7'h7f;
        repeat (3) @(negedge i_mclk);
        chk(o_src_level, 21'h1eb831);
        chk(o_src_fwd, 7'h7b);
        chk(top, 3'h7);
        acc(1, 16'hf644, 32'h4);
        repeat (2) @(negedge i_mclk);
        chk(o_irq, 0);
        acc(1, 16'hf644, 32'h2);
        repeat (2) @(negedge i_mclk);
        chk(o_irq, 1);
        acc(0, 16'hf640, 0);
        chk(q, 32'h7b);
        acc(0, 16'hf644, 0);
        chk(q, 32'h2);
        @(posedge i_mclk);
        i_src_req <= 7'h0;
        acc(1, 16'hf640, 32'h7f);
        repeat (2) @(negedge i_mclk);
        chk(o_irq, 0);
        acc(0, 16'hf640, 0);
        chk(q, 32'h0);
        // Top byte lane only
        be <= 4'h8;
        acc(1, 16'hf614, 32'h02ffffff);
        be <= 4'hf;
        acc(0, 16'hf614, 0);
        chk(q, 32'h02030601);
        // Reset again in mid-run
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        acc(0, 16'hf614, 0);
        chk(q, 32'h0);
        acc(0, 16'hf618, 0);
        chk(q, 32'h0);
        give_verdict;
    end
endmodule
`default_nettype wire
